// ===== rtl/vbr_pkg.sv
// Package for the bus requester: register map, field layout, timing and shared types
package vbr_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control register reset value (request level 3, demand mode, release when done)
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  // Writable bits of the control register; reserved bits read zero
  localparam logic [31:0] CTRL_WMASK = 32'hFEFF_0F7F;

  // Request level selecting the default line
  localparam logic [1:0] LEVEL_DEFAULT = 2'h3;

  // Tenure field value meaning done after every posted write
  localparam logic [3:0] POSTED_WRITE_TENURE_BYTES_EACH_WRITE = 4'hF;

  // DMA request threshold in bytes
  localparam int DMA_CHUNK_BYTES = 64;

  // Clock period and off-timer unit
  localparam int CLK_PERIOD_NS = 4;
  localparam int OFF_UNIT_NS = 1000;
  localparam int OFF_UNIT_CYC = (OFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles for which our own dropped request may still show on the filtered lines
  localparam logic [2:0] BR_ECHO_CYC = 3'h6;

  // Position of the synchronised pin groups inside the sampled vector
  localparam int SYN_BR_LSB = 0;
  localparam int SYN_BGIN_LSB = 4;
  localparam int SYN_BBSY_BIT = 8;
  localparam int SYN_IRQ_LSB = 9;
  localparam int SYN_W = 16;
  localparam logic [SYN_W-1:0] SYN_RST = 16'hFFFF;

  // One-hot grant of the master interface
  localparam logic [2:0] GR_NONE = 3'h0;
  localparam logic [2:0] GR_IRQ = 3'h1;
  localparam logic [2:0] GR_TGT = 3'h2;
  localparam logic [2:0] GR_DMA = 3'h4;

  // Bus tenure states
  typedef enum logic [1:0] {
    VS_IDLE = 2'b00,
    VS_REQ = 2'b01,
    VS_OWN = 2'b10
  } vbr_vstate_e;

  // Control register layout (master_control_reg)
  typedef struct packed {
    logic [6:0] irq_en;        // 31:25 enables for interrupt lines 7..1
    logic rsv3;                // 24
    logic [7:0] off_time;      // 23:16 DMA off interval in units
    logic [3:0] rsv2;          // 15:12
    logic [3:0] posted_write_tenure_bytes;          // 11:8 posted_write_tenure_bytes
    logic rsv1;                // 7
    logic off_en;              // 6 DMA off-timer enable
    logic own_irq_en;          // 5 interrupt on ownership ack
    logic own_req;             // 4 ownership_request_bit
    logic release_on_request;                 // 3 release_mode_select: 1 release_on_request
    logic fair;                // 2 request_mode_select: 1 fair
    logic [1:0] level;         // 1:0 request_level_field
  } vbr_ctrl_s;

  // Status register layout
  typedef struct packed {
    logic [23:0] rsv;          // 31:8
    logic [1:0] vstate;        // 7:6
    logic [2:0] grant;         // 5:3
    logic tx_empty;            // 2 tx_queue_empty_flag
    logic own_busy;            // 1 own_busy_status, 0 while driving busy
    logic own_ack;             // 0 ownership_ack_bit
  } vbr_stat_s;

endpackage

// ===== rtl/vbr_requester.sv
// Bus requester: internal channel arbiter, bus request and release, Wishbone registers
// Function
// R1 - Interrupt channel always wins; DMA and host target alternate fairly.
// R2 - A granted channel keeps the master interface until its own completion.
// R3 - Interrupt channel requests when an enabled interrupt line is asserted.
// R4 - Target channel requests on a complete queued write or coupled cycle request.
// R5 - DMA requests at 64 bytes free/held, or when its block ends.
// R6 - With off-timer enabled, DMA stays off the bus for the programmed interval.
// R7 - Ownership request acquires the bus, sets ownership ack, optional host interrupt.
// R8 - Bus held until software clears the ownership request; busy not released.
// R9 - During an ownership tenure DMA is blocked from the master interface.
// R10 - Request level field picks one of four request lines, default level 3.
// R11 - Fair mode waits until no request is pending on our level.
// R12 - Demand mode (default) requests whenever needed, ignoring the level line.
// R13 - Release on request: drop busy only when others request and owner done.
// R14 - Release on request, no requests pending: next channel keeps the bus.
// R15 - Release when done (default): drop busy as soon as the owner is done.
// R16 - Own busy status reads 0 while this block drives busy.
// R17 - Interrupt channel done after exactly one acknowledge cycle.
// R18 - Target done on empty queue or tenure byte limit reached.
// R19 - Tenure field all ones: target done after each posted write.
// R20 - Target done on coupled completion plus window expiry, or request timeout.
// R21 - Byte limit ignored while ownership request holds the bus.
// R22 - DMA done on full, empty, error, tenure counter expiry or block end.
// R23 - Bus clear is not monitored; tenure never shortened by it.
// R24 - After granting target or DMA, the other wins the next tie.
module vbr_requester #(
  parameter int DMA_DEPTH_BYTES = 256,
  parameter int FILL_W = 9,
  parameter int POSTED_WRITE_TENURE_BYTES_SHIFT = 7
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_WB_ERR,
  // Interrupt channel
  input wire logic [7:1] I_IRQ_N,
  input wire logic I_IACK_DONE,
  // Host target channel
  input wire logic I_TX_HAS_TXN,
  input wire logic I_TX_EMPTY,
  input wire logic I_TGT_BEAT,
  input wire logic [7:0] I_TGT_BYTES,
  input wire logic I_TGT_PWR_DONE,
  input wire logic I_CPL_REQ,
  input wire logic I_CPL_DONE,
  input wire logic I_CWIN_EXP,
  input wire logic I_CREQ_TMO,
  // DMA channel
  input wire logic I_DMA_ACTIVE,
  input wire logic I_DMA_TO_VME,
  input wire logic [FILL_W-1:0] I_DMA_FILL,
  input wire logic I_DMA_BLK_END,
  input wire logic I_DMA_BLK_DONE,
  input wire logic I_DMA_ERR,
  input wire logic I_DMA_TENURE_EXP,
  // Master interface grant
  output logic [2:0] O_GRANT,
  output logic O_OWN_IRQ,
  // Bus arbitration pins
  input wire logic [3:0] I_BR_N,
  output logic [3:0] O_BR_O,
  output logic [3:0] O_BR_OE,
  input wire logic [3:0] I_BGIN_N,
  output logic [3:0] O_BGOUT_N,
  input wire logic I_BBSY_N,
  output logic O_BBSY_O,
  output logic O_BBSY_OE
);

  vbr_pkg::vbr_ctrl_s ctrl;
  vbr_pkg::vbr_vstate_e vstate;
  vbr_pkg::vbr_vstate_e next_vstate;
  logic [vbr_pkg::SYN_W-1:0] syn1, syn2, syn3, synf;
  logic [2:0] grant, next_grant;
  logic own_ack, iack_served, tgt_last, tgt_coupled, cpl_seen;
  logic [15:0] tgt_bytes;
  logic [17:0] off_cnt;
  logic [3:0] lvl_onehot, br_n_f, bgin_n_f;
  logic bbsy_free, br_at_level, others_req;
  logic [2:0] br_echo;
  logic irq_req, tgt_req, dma_req, want_bus, arb_ok;
  logic tgt_done, dma_done, ch_done, rel_now, lim_hit;
  logic [FILL_W-1:0] dma_free;
  logic [15:0] tgt_limit;
  logic wb_req, wb_hit;
  logic [31:0] wr_merge;
  vbr_pkg::vbr_stat_s stat;

  // Pin sampling: three stages, a change is taken once stages two and three agree
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      syn1 <= vbr_pkg::SYN_RST;
      syn2 <= vbr_pkg::SYN_RST;
      syn3 <= vbr_pkg::SYN_RST;
      synf <= vbr_pkg::SYN_RST;
    end else begin
      syn1 <= {I_IRQ_N, I_BBSY_N, I_BGIN_N, I_BR_N};
      syn2 <= syn1;
      syn3 <= syn2;
      synf <= ((syn2 ~^ syn3) & syn3) | ((syn2 ^ syn3) & synf);
    end
  end

  // Filtered pin views; bus clear is deliberately not sampled at all [R23]
  assign br_n_f = synf[vbr_pkg::SYN_BR_LSB +: 4];
  assign bgin_n_f = synf[vbr_pkg::SYN_BGIN_LSB +: 4];
  assign bbsy_free = synf[vbr_pkg::SYN_BBSY_BIT];
  assign lvl_onehot = 4'h1 << ctrl.level;                                 // [R10]
  assign br_at_level = |(~br_n_f & lvl_onehot);
  assign others_req = |(~br_n_f & ~(lvl_onehot & {4{br_echo != 3'h0}}));   // [R13] [R14]

  // Own request echo: mask our level until the filter no longer shows our request
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      br_echo <= 3'h0;
    end else if (O_BR_OE != 4'h0) begin
      br_echo <= vbr_pkg::BR_ECHO_CYC;
    end else if (br_echo != 3'h0) begin
      br_echo <= br_echo - 3'h1;
    end
  end

  // Interrupt channel request on an enabled, not yet served line
  assign irq_req = (|(~synf[vbr_pkg::SYN_IRQ_LSB +: 7] & ctrl.irq_en)) & !iack_served; // [R3]

  // Target channel request
  assign tgt_req = I_TX_HAS_TXN | I_CPL_REQ;                                // [R4]

  // DMA channel request with off-timer qualification
  assign dma_free = FILL_W'(DMA_DEPTH_BYTES) - I_DMA_FILL;
  assign dma_req = I_DMA_ACTIVE && (off_cnt == 18'h0_0000) &&                // [R6]
                   ((I_DMA_TO_VME ? (I_DMA_FILL >= FILL_W'(vbr_pkg::DMA_CHUNK_BYTES))
                                  : (dma_free >= FILL_W'(vbr_pkg::DMA_CHUNK_BYTES)))
                    || I_DMA_BLK_END);                                       // [R5]

  // Anything that needs the bus
  assign want_bus = irq_req | tgt_req | (dma_req & !ctrl.own_req) | (ctrl.own_req & !own_ack);

  // Target completion conditions
  assign tgt_limit = 16'(({12'h000, ctrl.posted_write_tenure_bytes} + 16'h0001) << POSTED_WRITE_TENURE_BYTES_SHIFT);
  assign lim_hit = !ctrl.own_req && (tgt_bytes >= tgt_limit);             // [R21]
  always_comb begin
    if (tgt_coupled) begin
      tgt_done = ((cpl_seen | I_CPL_DONE) & I_CWIN_EXP) | I_CREQ_TMO;       // [R20]
    end else begin
      tgt_done = I_TX_EMPTY | lim_hit                                      // [R18]
                 | ((ctrl.posted_write_tenure_bytes == vbr_pkg::POSTED_WRITE_TENURE_BYTES_EACH_WRITE) & I_TGT_PWR_DONE); // [R19]
    end
  end

  // DMA completion conditions
  assign dma_done = (!I_DMA_TO_VME && (dma_free == '0)) || (I_DMA_TO_VME && (I_DMA_FILL == '0))
                    || I_DMA_ERR || I_DMA_TENURE_EXP || I_DMA_BLK_DONE;      // [R22]

  // Completion of whichever channel holds the grant
  always_comb begin
    case (grant)
      vbr_pkg::GR_IRQ: ch_done = I_IACK_DONE;                              // [R17]
      vbr_pkg::GR_TGT: ch_done = tgt_done;
      vbr_pkg::GR_DMA: ch_done = dma_done;
      default: ch_done = 1'b0;
    endcase
  end

  // Release decision while owning the bus
  always_comb begin
    if (ctrl.own_req) begin
      rel_now = 1'b0;                                                      // [R8]
    end else if (grant == vbr_pkg::GR_NONE) begin
      rel_now = ctrl.release_on_request ? others_req : !want_bus;                         // [R14]
    end else begin
      rel_now = ch_done && (!ctrl.release_on_request || others_req);                      // [R13] [R15]
    end
  end

  // Arbiter may hand out the master interface
  assign arb_ok = (vstate == vbr_pkg::VS_OWN) && (grant == vbr_pkg::GR_NONE) && !rel_now;

  // Next grant: interrupt first, then alternate target and DMA
  always_comb begin
    next_grant = grant;
    if (vstate != vbr_pkg::VS_OWN) begin
      next_grant = vbr_pkg::GR_NONE;
    end else if (grant != vbr_pkg::GR_NONE) begin
      if (ch_done) begin
        next_grant = vbr_pkg::GR_NONE;                                     // [R2]
      end
    end else if (arb_ok) begin
      if (irq_req) begin
        next_grant = vbr_pkg::GR_IRQ;                                      // [R1]
      end else if (tgt_req && dma_req && !ctrl.own_req) begin
        next_grant = tgt_last ? vbr_pkg::GR_DMA : vbr_pkg::GR_TGT;         // [R24]
      end else if (tgt_req) begin
        next_grant = vbr_pkg::GR_TGT;
      end else if (dma_req && !ctrl.own_req) begin
        next_grant = vbr_pkg::GR_DMA;                                      // [R9]
      end
    end
  end

  // Bus tenure sequence
  always_comb begin
    next_vstate = vstate;
    case (vstate)
      vbr_pkg::VS_IDLE: begin
        if (want_bus && (!ctrl.fair || !br_at_level)) begin                 // [R11] [R12]
          next_vstate = vbr_pkg::VS_REQ;
        end
      end
      vbr_pkg::VS_REQ: begin
        if (bbsy_free && |(~bgin_n_f & lvl_onehot)) begin
          next_vstate = vbr_pkg::VS_OWN;
        end
      end
      vbr_pkg::VS_OWN: begin
        if (rel_now) begin
          next_vstate = vbr_pkg::VS_IDLE;
        end
      end
      default: next_vstate = vbr_pkg::VS_IDLE;
    endcase
  end

  // Tenure state and grant registers
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      vstate <= vbr_pkg::VS_IDLE;
      grant <= vbr_pkg::GR_NONE;
    end else begin
      vstate <= next_vstate;
      grant <= next_grant;
    end
  end

  // Fairness memory between target and DMA
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tgt_last <= 1'b0;
    end else if (grant == vbr_pkg::GR_NONE && next_grant == vbr_pkg::GR_TGT) begin
      tgt_last <= 1'b1;                                                    // [R24]
    end else if (grant == vbr_pkg::GR_NONE && next_grant == vbr_pkg::GR_DMA) begin
      tgt_last <= 1'b0;
    end
  end

  // Served interrupt: set on acknowledge done (set wins), cleared when lines drop
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      iack_served <= 1'b0;
    end else if (grant == vbr_pkg::GR_IRQ && I_IACK_DONE) begin
      iack_served <= 1'b1;                                                 // [R17]
    end else if (!(|(~synf[vbr_pkg::SYN_IRQ_LSB +: 7] & ctrl.irq_en))) begin
      iack_served <= 1'b0;
    end
  end

  // Target tenure bookkeeping: mode latch, byte count, coupled completion seen
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tgt_coupled <= 1'b0;
      tgt_bytes <= 16'h0000;
      cpl_seen <= 1'b0;
    end else if (grant != vbr_pkg::GR_TGT) begin
      tgt_coupled <= I_CPL_REQ && !I_TX_HAS_TXN;
      tgt_bytes <= 16'h0000;
      cpl_seen <= 1'b0;
    end else begin
      if (I_TGT_BEAT) begin
        tgt_bytes <= tgt_bytes + {8'h00, I_TGT_BYTES};                     // [R18]
      end
      if (I_CPL_DONE) begin
        cpl_seen <= 1'b1;
      end
    end
  end

  // DMA off-timer: loaded when the DMA tenure ends, counts down to zero
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      off_cnt <= 18'h0_0000;
    end else if (grant == vbr_pkg::GR_DMA && dma_done && ctrl.off_en) begin
      off_cnt <= 18'(ctrl.off_time * vbr_pkg::OFF_UNIT_CYC);               // [R6]
    end else if (off_cnt != 18'h0_0000) begin
      off_cnt <= off_cnt - 18'h0_0001;
    end
  end

  // Ownership acknowledge follows the software request once the bus is held
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      own_ack <= 1'b0;
      O_OWN_IRQ <= 1'b0;
    end else begin
      own_ack <= ctrl.own_req && (own_ack || vstate == vbr_pkg::VS_OWN);    // [R7]
      O_OWN_IRQ <= ctrl.own_irq_en && ctrl.own_req && (own_ack || vstate == vbr_pkg::VS_OWN);
    end
  end

  // Pin drivers: request at the programmed level, busy while owning, grant daisy chain
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BR_O <= 4'h0;
      O_BR_OE <= 4'h0;
      O_BBSY_O <= 1'b0;
      O_BBSY_OE <= 1'b0;
      O_BGOUT_N <= 4'hF;
      O_GRANT <= vbr_pkg::GR_NONE;
    end else begin
      O_BR_O <= 4'h0;
      O_BR_OE <= (next_vstate == vbr_pkg::VS_REQ) ? lvl_onehot : 4'h0;     // [R10]
      O_BBSY_O <= 1'b0;
      O_BBSY_OE <= (next_vstate == vbr_pkg::VS_OWN);
      O_BGOUT_N <= bgin_n_f | (lvl_onehot & {4{next_vstate != vbr_pkg::VS_IDLE}});
      O_GRANT <= next_grant;
    end
  end

  // Status view; busy status reads 0 while driving busy
  always_comb begin
    stat = '0;
    stat.own_ack = own_ack;
    stat.own_busy = !O_BBSY_OE;                                            // [R16]
    stat.tx_empty = I_TX_EMPTY;
    stat.grant = grant;
    stat.vstate = vstate;
  end

  // Wishbone decode and byte-lane merge
  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK && !O_WB_ERR;
  assign wb_hit = (I_WB_ADR[7:2] == vbr_pkg::CTRL_OFS[7:2]) || (I_WB_ADR[7:2] == vbr_pkg::STAT_OFS[7:2]);
  always_comb begin
    wr_merge = ctrl;
    for (int b = 0; b < 4; b++) begin
      if (I_WB_SEL[b]) begin
        wr_merge[b*8 +: 8] = I_WB_DAT[b*8 +: 8];
      end
    end
  end

  // Control register write, taken at the edge that sees the acknowledge
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl <= vbr_pkg::vbr_ctrl_s'(vbr_pkg::CTRL_RST);
    end else if (I_WB_CYC && I_WB_STB && O_WB_ACK && I_WB_WE && I_WB_ADR[7:2] == vbr_pkg::CTRL_OFS[7:2]) begin
      ctrl <= vbr_pkg::vbr_ctrl_s'(wr_merge & vbr_pkg::CTRL_WMASK);
    end
  end

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WB_ACK <= 1'b0;
      O_WB_ERR <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= wb_req && wb_hit;
      O_WB_ERR <= wb_req && !wb_hit;
      if (wb_req && !I_WB_WE && I_WB_ADR[7:2] == vbr_pkg::CTRL_OFS[7:2]) begin
        O_WB_DAT <= ctrl;
      end else if (wb_req && !I_WB_WE && I_WB_ADR[7:2] == vbr_pkg::STAT_OFS[7:2]) begin
        O_WB_DAT <= stat;
      end else begin
        O_WB_DAT <= 32'h0000_0000;
      end
    end
  end

  // Checks on the arbiter and the tenure sequence
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  sequence s_demand_idle;
    vstate == vbr_pkg::VS_IDLE && want_bus && !ctrl.fair;
  endsequence
  sequence s_requesting;
    O_BR_OE == $past(lvl_onehot) && !O_BBSY_OE;
  endsequence
  sequence s_won;
    vstate == vbr_pkg::VS_REQ && next_vstate == vbr_pkg::VS_OWN;
  endsequence
  sequence s_owning;
    vstate == vbr_pkg::VS_OWN && O_BBSY_OE && O_BR_OE == 4'h0;
  endsequence

  irq_priority_a: assert property ((arb_ok && irq_req) |=> grant == vbr_pkg::GR_IRQ) // [R1]
    else $error("interrupt channel lost arbitration");
  grant_hold_a: assert property ((grant != vbr_pkg::GR_NONE && !ch_done) |=> grant == $past(grant)) // [R2]
    else $error("grant moved before channel done");
  dma_off_a: assert property ((off_cnt != 18'h0_0000) |-> !dma_req) // [R6]
    else $error("DMA requested during off interval");
  own_ack_a: assert property ((vstate == vbr_pkg::VS_OWN && ctrl.own_req) |=> own_ack) // [R7]
    else $error("ownership ack not set while owning");
  own_hold_a: assert property ((vstate == vbr_pkg::VS_OWN && ctrl.own_req) |=> O_BBSY_OE) // [R8]
    else $error("busy dropped while ownership requested");
  dma_blocked_a: assert property ((arb_ok && ctrl.own_req) |=> grant != vbr_pkg::GR_DMA) // [R9]
    else $error("DMA granted during ownership tenure");
  demand_req_a: assert property (s_demand_idle |=> s_requesting) // [R12]
    else $error("demand request not driven on level");
  fair_wait_a: assert property ((vstate == vbr_pkg::VS_IDLE && ctrl.fair && br_at_level) |=> O_BR_OE == 4'h0) // [R11]
    else $error("fair mode requested over pending level");
  acquire_a: assert property (s_won |=> s_owning) // [R10]
    else $error("bus not taken after grant");
  rwd_release_a: assert property ((vstate == vbr_pkg::VS_OWN && !ctrl.release_on_request && !ctrl.own_req
                                   && grant != vbr_pkg::GR_NONE && ch_done) |=> !O_BBSY_OE) // [R15]
    else $error("busy held after done in release when done");
  ror_keep_a: assert property ((vstate == vbr_pkg::VS_OWN && ctrl.release_on_request && !others_req
                                && grant != vbr_pkg::GR_NONE && ch_done) |=> O_BBSY_OE) // [R14]
    else $error("busy released with no outside request");
  busy_stat_a: assert property ($rose(O_BBSY_OE) |-> ##1 stat.own_busy == 1'b0 [*2]) // [R16]
    else $error("busy status not zero while driving busy");

endmodule

// ===== tb/vbr_arb_model.sv
// Behavioural system arbiter driving the grant daisy chain into the requester
module vbr_arb_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Resolved bus lines and grant delay
  input wire logic [3:0] i_br_n,
  input wire logic i_bbsy_n,
  input wire logic [3:0] i_dly,
  // Grant daisy chain into the requester
  output logic [3:0] o_bgin_n
);
  logic [3:0] wait_cnt;

  // Grant highest pending level once the bus is free and the delay has run out
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bgin_n <= 4'hF;
      wait_cnt <= 4'h0;
    end else if (!i_bbsy_n || i_br_n == 4'hF) begin
      o_bgin_n <= 4'hF; // Grant withdrawn once busy is taken or requests vanish
      wait_cnt <= 4'h0;
    end else if (wait_cnt < i_dly) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      casez (i_br_n)
        4'b0???: o_bgin_n <= 4'b0111;
        4'b10??: o_bgin_n <= 4'b1011;
        4'b110?: o_bgin_n <= 4'b1101;
        default: o_bgin_n <= 4'b1110;
      endcase
    end
  end
endmodule

// ===== tb/vme_bus_requester_tb.sv
// Self-checking bench for the bus requester
module vme_bus_requester_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, err, iack = 0, txh = 0, txe = 1, beat = 0, pwd = 0;
  logic cpr = 0, cpd = 0, cwx = 0, crt = 0, dma = 0, tov = 1, bke = 0, bkd = 0, der = 0, dtx = 0, oirq, bo;
  logic bbsy_oe;
  logic [7:0] adr = 0, tby = 0;
  logic [3:0] sel = 4'hF, obr = 0, dly = 0, bro, br_oe, bgin_n, bgo;
  logic [31:0] wd = 0, rdat, q;
  logic [7:1] irq_n = 7'h7F;
  logic [8:0] fill = 0;
  logic [2:0] grant;
  logic e;
  int num_errors = 0, check_count = 0;
  wire logic [3:0] br_n = ~(br_oe | obr);
  wire logic bbsy_n = ~bbsy_oe;

  vbr_requester vbr_requester_i (.I_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_WB_ERR(err),
    .I_IRQ_N(irq_n), .I_IACK_DONE(iack), .I_TX_HAS_TXN(txh), .I_TX_EMPTY(txe), .I_TGT_BEAT(beat),
    .I_TGT_BYTES(tby), .I_TGT_PWR_DONE(pwd), .I_CPL_REQ(cpr), .I_CPL_DONE(cpd), .I_CWIN_EXP(cwx),
    .I_CREQ_TMO(crt), .I_DMA_ACTIVE(dma), .I_DMA_TO_VME(tov), .I_DMA_FILL(fill), .I_DMA_BLK_END(bke),
    .I_DMA_BLK_DONE(bkd), .I_DMA_ERR(der), .I_DMA_TENURE_EXP(dtx), .O_GRANT(grant), .O_OWN_IRQ(oirq),
    .I_BR_N(br_n), .O_BR_O(bro), .O_BR_OE(br_oe), .I_BGIN_N(bgin_n), .O_BGOUT_N(bgo), .I_BBSY_N(bbsy_n),
    .O_BBSY_O(bo), .O_BBSY_OE(bbsy_oe));
  vbr_arb_model vbr_arb_model_i (.i_clk(clk), .i_nrst(nrst), .i_br_n(br_n), .i_bbsy_n(bbsy_n), .i_dly(dly),
    .o_bgin_n(bgin_n));

  // Clock of 4 ns period
  always #2 clk = ~clk;

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  // One classic Wishbone cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = rdat;
    e = err;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk);
    if (n >= 50) begin
      chk(1, 0);
      stop_test();
    end
  endtask

  // Bounded wait for busy drive and grant to reach a value
  task automatic wait_st(input logic [3:0] v);
    int n;
    n = 0;
    while ({bbsy_oe, grant} !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      chk({bbsy_oe, grant}, v);
      stop_test();
    end
  endtask

  // Reset values, unmapped access, target tenure in release-when-done
  task automatic t_target();
    wb(0, vbr_pkg::CTRL_OFS, 0);
    chk(q, vbr_pkg::CTRL_RST);
    wb(0, 8'h40, 0);
    chk(e, 1);
    wb(0, vbr_pkg::STAT_OFS, 0);
    chk(q[1], 1);
    txh <= 1;
    txe <= 0;
    repeat (2) @(posedge clk);
    chk(br_oe, 4'b1000);
    wait_st({1'b1, vbr_pkg::GR_TGT});
    wb(0, vbr_pkg::STAT_OFS, 0);
    chk(q[1], 0);
    txh <= 0;
    txe <= 1;
    wait_st(4'h0);
  endtask

  // Fair mode on level 1 waits for the other master, slow arbiter
  task automatic t_fair();
    wb(1, vbr_pkg::CTRL_OFS, 32'h0000_0005);
    dly <= 4'h8;
    obr <= 4'b0010;
    repeat (6) @(posedge clk);
    txh <= 1;
    txe <= 0;
    repeat (12) @(posedge clk);
    chk(br_oe, 0);
    chk(bgo, 4'b1101);
    obr <= 0;
    repeat (7) @(posedge clk);
    chk(br_oe, 4'b0010);
    wait_st({1'b1, vbr_pkg::GR_TGT});
    txh <= 0;
    txe <= 1;
    wait_st(4'h0);
    dly <= 0;
  endtask

  // Interrupt beats DMA; release when done then DMA re-arbitrates
  task automatic t_prio();
    wb(1, vbr_pkg::CTRL_OFS, 32'h0200_0003);
    dma <= 1;
    fill <= 9'd64;
    irq_n[1] <= 0;
    wait_st({1'b1, vbr_pkg::GR_IRQ});
    irq_n[1] <= 1;
    iack <= 1;
    @(posedge clk);
    iack <= 0;
    wait_st(4'h0);
    wait_st({1'b1, vbr_pkg::GR_DMA});
    fill <= 0;
    wait_st(4'h0);
    dma <= 0;
  endtask

  // Release on request: bus kept between channels until another master asks
  task automatic t_ror();
    wb(1, vbr_pkg::CTRL_OFS, 32'h0000_000B);
    txh <= 1;
    txe <= 0;
    wait_st({1'b1, vbr_pkg::GR_TGT});
    txh <= 0;
    txe <= 1;
    wait_st({1'b1, vbr_pkg::GR_NONE});
    dma <= 1;
    fill <= 9'd64;
    wait_st({1'b1, vbr_pkg::GR_DMA});
    fill <= 0;
    dma <= 0;
    wait_st({1'b1, vbr_pkg::GR_NONE});
    obr <= 4'b0001;
    wait_st(4'h0);
    obr <= 0;
  endtask

  // Ownership bit holds the bus and blocks DMA
  task automatic t_own();
    wb(1, vbr_pkg::CTRL_OFS, 32'h0000_0033);
    wait_st({1'b1, vbr_pkg::GR_NONE});
    wb(0, vbr_pkg::STAT_OFS, 0);
    chk(q[1:0], 2'b01);
    chk(oirq, 1);
    dma <= 1;
    fill <= 9'd64;
    repeat (20) @(posedge clk);
    chk({bbsy_oe, grant}, 4'b1000);
    dma <= 0;
    wb(1, vbr_pkg::CTRL_OFS, 32'h0000_0003);
    wait_st(4'h0);
  endtask

  // Tenure field all ones, then coupled cycle completion
  task automatic t_tgt_done();
    wb(1, vbr_pkg::CTRL_OFS, 32'h0000_0F03);
    txh <= 1;
    txe <= 0;
    wait_st({1'b1, vbr_pkg::GR_TGT});
    txh <= 0;
    pwd <= 1;
    @(posedge clk);
    pwd <= 0;
    wait_st(4'h0);
    cpr <= 1;
    wait_st({1'b1, vbr_pkg::GR_TGT});
    cpr <= 0;
    cpd <= 1;
    @(posedge clk);
    cpd <= 0;
    repeat (3) @(posedge clk);
    chk(grant, vbr_pkg::GR_TGT);
    cwx <= 1;
    wait_st(4'h0);
    cwx <= 0;
    txe <= 1;
  endtask

  // DMA off-timer keeps the next DMA request back for one unit
  task automatic t_off();
    int n;
    n = 0;
    wb(1, vbr_pkg::CTRL_OFS, 32'h0001_0043);
    dma <= 1;
    fill <= 9'd64;
    wait_st({1'b1, vbr_pkg::GR_DMA});
    fill <= 0;
    wait_st(4'h0);
    fill <= 9'd64;
    while (br_oe === 4'h0 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk((n >= vbr_pkg::OFF_UNIT_CYC) && (n <= vbr_pkg::OFF_UNIT_CYC + 4), 1);
    wait_st({1'b1, vbr_pkg::GR_DMA});
    fill <= 0;
    dma <= 0;
    wait_st(4'h0);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_target();
    t_fair();
    t_prio();
    t_ror();
    t_own();
    t_tgt_done();
    t_off();
    stop_test();
  end
endmodule
